// File: hw/bdc_control.sv
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - enable bit powers comparator; output ignored for three slow ticks after enabling.
// - two-bit threshold field drives comparator reference, codes 11 to 00.
// - any filtered crossing, down or up, sets the crossing flag.
// - interrupt request is flag and block enable and global enable.
// - flag stays set until software writes zero.
// - with reset enable set, being below threshold requests system reset.
// - hardware sets the reset flag whenever a brown-out reset occurs.
// - status bit reads below-threshold while enabled, else zero; read-only.
// - enable, threshold and reset enable reload from config byte after reset.
// - flag resets to one only if enabled, no reset, and below.
// - duty field: always on, or sampled every 16, 64, 256 slow ticks.
// - filter needs 32 system clocks in fast always-on mode, else 2 ticks.
// - in power-down the output is always filtered by 2 slow ticks.
// - filter enable bit switches filter; power-on reset sets it.
// - flag is not set again until a new crossing happens.
// - a drop raises the interrupt path whether reset enable is set or not.
// - control writes need the unlock sequence first; others are ignored.
module bdc_control (
   input wire logic clk, // 100 MHz system clock
   input wire logic reset_n, // any reset, async, active low
   input wire logic porReset_n, // power-on reset only, async
   input wire logic [7:0] sfrAddr, // register address
   input wire logic sfrWe, // write strobe, one cycle
   input wire logic [7:0] sfrWdata, // write data
   output logic [7:0] sfrRdata, // read data, one cycle late
   input wire logic [7:0] nvConfigByteTwo, // nonvolatile config byte
   input wire logic cmpRaw, // async comparator, 1 = below
   input wire logic lircClk, // slow oscillator, sampled
   input wire logic sysClkIsLirc, // system runs from slow osc
   input wire logic powerDown, // cpu halted in power-down
   input wire logic brownoutIrqEnable, // block interrupt enable
   input wire logic globalIrqEnable, // global interrupt enable
   output logic cmpEnable, // comparator power
   output logic [1:0] cmpThreshold, // comparator reference select
   output logic irqReq, // interrupt request level
   output logic supplyDropReset // system reset request level
);
   // -----------------------------------------------------------------
   // synchronisers
   // -----------------------------------------------------------------
   logic cmpMeta_reg, cmpSync_reg, lircMeta_reg, lircSync_reg, lircPrev_reg;
   logic lircTick;

   // both are async to clk; first stage feeds only the second
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cmpMeta_reg <= 1'b0;
         cmpSync_reg <= 1'b0;
         lircMeta_reg <= 1'b0;
         lircSync_reg <= 1'b0;
         lircPrev_reg <= 1'b0;
      end else begin
         cmpMeta_reg <= cmpRaw;
         cmpSync_reg <= cmpMeta_reg;
         lircMeta_reg <= lircClk;
         lircSync_reg <= lircMeta_reg;
         lircPrev_reg <= lircSync_reg;
      end
   end

   assign lircTick = lircSync_reg && !lircPrev_reg;

   // -----------------------------------------------------------------
   // duty period lookup
   // -----------------------------------------------------------------
   function automatic logic [8:0] dutyPeriod(input logic [1:0] mode);
      unique case (mode)
         2'h1: dutyPeriod = bdc_pkg::DUTY1_PERIOD_TICKS;
         2'h2: dutyPeriod = bdc_pkg::DUTY2_PERIOD_TICKS;
         2'h3: dutyPeriod = bdc_pkg::DUTY3_PERIOD_TICKS;
         2'h0: dutyPeriod = bdc_pkg::DUTY1_PERIOD_TICKS;
      endcase
   endfunction

   // -----------------------------------------------------------------
   // control state
   // -----------------------------------------------------------------
   logic detEn_reg, detEn_next;
   logic [1:0] thr_reg, thr_next;
   logic crossFlag_reg, crossFlag_next;
   logic dropRstEn_reg, dropRstEn_next;
   logic [1:0] duty_reg, duty_next;
   logic [1:0] load_reg, load_next;
   logic unlockArmed_reg, unlockArmed_next;
   logic [2:0] unlockOpen_reg, unlockOpen_next;
   logic [1:0] settle_reg, settle_next;
   logic [8:0] dutyCnt_reg, dutyCnt_next;
   logic [7:0] rdata_reg, rdata_next;
   logic wrPrimary, wrSecondary, protectedOk, settling, dutyWindow;
   logic filtAccepted, filtChange, filtBypass, filtUseSys, loaded;
   logic nvDetEn, nvDropRst;
   logic dropFlag_reg, dropFlag_next, filterEn_reg, filterEn_next;

   assign nvDetEn = nvConfigByteTwo[bdc_pkg::NV_DET_EN_BIT];
   assign nvDropRst = nvConfigByteTwo[bdc_pkg::NV_DROP_RST_BIT];
   assign loaded = load_reg == 2'h0;
   assign protectedOk = unlockOpen_reg != 3'h0 && loaded;
   // a write outside the unlock window is dropped silently
   assign wrPrimary = sfrWe && sfrAddr == bdc_pkg::CTRL_PRIMARY_ADDR && protectedOk;
   assign wrSecondary = sfrWe && sfrAddr == bdc_pkg::CTRL_SECONDARY_ADDR && protectedOk;
   assign settling = settle_reg != 2'h0;
   assign dutyWindow = duty_reg == 2'h0 ||
      dutyCnt_reg >= dutyPeriod(duty_reg) - bdc_pkg::DUTY_ON_TICKS;

   // register next values, unlock, load and duty timers
   always_comb begin
      detEn_next = detEn_reg;
      thr_next = thr_reg;
      crossFlag_next = crossFlag_reg;
      dropRstEn_next = dropRstEn_reg;
      duty_next = duty_reg;
      load_next = loaded ? 2'h0 : load_reg - 2'h1;
      unlockArmed_next = 1'b0;
      unlockOpen_next = unlockOpen_reg != 3'h0 ? unlockOpen_reg - 3'h1 : 3'h0;
      settle_next = settle_reg;
      dutyCnt_next = dutyCnt_reg;
      // unlock: second key must follow the first with no other write between
      if (sfrWe && sfrAddr == bdc_pkg::TIMED_UNLOCK_ADDR) begin
         if (sfrWdata == bdc_pkg::UNLOCK_KEY_FIRST) begin
            unlockArmed_next = 1'b1;
         end else if (sfrWdata == bdc_pkg::UNLOCK_KEY_SECOND && unlockArmed_reg) begin
            unlockOpen_next = bdc_pkg::UNLOCK_WINDOW_CYCLES;
         end
      end else if (sfrWe) begin
         unlockOpen_next = 3'h0; // one protected write per unlock
      end else begin
         unlockArmed_next = unlockArmed_reg;
      end
      // sync stages fill before the config byte is trusted
      if (load_reg == 2'h1) begin
         detEn_next = nvDetEn;
         thr_next = nvConfigByteTwo[bdc_pkg::NV_THR_LSB +: 2];
         dropRstEn_next = nvDropRst;
         crossFlag_next = nvDetEn && !nvDropRst && cmpSync_reg;
      end
      if (wrPrimary) begin
         detEn_next = sfrWdata[bdc_pkg::DET_EN_BIT];
         thr_next = sfrWdata[bdc_pkg::THR_LSB +: 2];
         crossFlag_next = sfrWdata[bdc_pkg::CROSS_FLAG_BIT];
         dropRstEn_next = sfrWdata[bdc_pkg::DROP_RST_EN_BIT];
      end
      if (wrSecondary) begin
         duty_next = sfrWdata[bdc_pkg::DUTY_LSB +: 2];
      end
      // the crossing wins over a clearing write in the same cycle
      if (filtChange) begin
         crossFlag_next = 1'b1;
      end
      // output invalid for a few slow ticks after enabling
      if (detEn_next && !detEn_reg) begin
         settle_next = bdc_pkg::SETTLE_LOW_SPEED_INTERNAL_OSC_TICKS;
      end else if (lircTick && settling) begin
         settle_next = settle_reg - 2'h1;
      end
      if (duty_reg == 2'h0) begin
         dutyCnt_next = 9'h000;
      end else if (lircTick) begin
         dutyCnt_next = dutyCnt_reg + 9'h001 >= dutyPeriod(duty_reg) ? 9'h000 : dutyCnt_reg + 9'h001;
      end
      // status bit is computed live; writes cannot reach it
      rdata_next = 8'h00;
      if (sfrAddr == bdc_pkg::CTRL_PRIMARY_ADDR) begin
         rdata_next[bdc_pkg::DET_EN_BIT] = detEn_reg;
         rdata_next[bdc_pkg::THR_LSB +: 2] = thr_reg;
         rdata_next[bdc_pkg::CROSS_FLAG_BIT] = crossFlag_reg;
         rdata_next[bdc_pkg::DROP_RST_EN_BIT] = dropRstEn_reg;
         rdata_next[bdc_pkg::DROP_RST_FLAG_BIT] = dropFlag_reg;
         rdata_next[bdc_pkg::BELOW_STATUS_BIT] = detEn_reg && filtAccepted;
      end else if (sfrAddr == bdc_pkg::CTRL_SECONDARY_ADDR) begin
         rdata_next[bdc_pkg::DUTY_LSB +: 2] = duty_reg;
         rdata_next[bdc_pkg::FILTER_EN_BIT] = filterEn_reg;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         detEn_reg <= 1'b0;
         thr_reg <= 2'h0;
         crossFlag_reg <= 1'b0;
         dropRstEn_reg <= 1'b0;
         duty_reg <= 2'h0;
         load_reg <= bdc_pkg::LOAD_DELAY_CYCLES;
         unlockArmed_reg <= 1'b0;
         unlockOpen_reg <= 3'h0;
         settle_reg <= 2'h0;
         dutyCnt_reg <= 9'h000;
         rdata_reg <= 8'h00;
      end else begin
         detEn_reg <= detEn_next;
         thr_reg <= thr_next;
         crossFlag_reg <= crossFlag_next;
         dropRstEn_reg <= dropRstEn_next;
         duty_reg <= duty_next;
         load_reg <= load_next;
         unlockArmed_reg <= unlockArmed_next;
         unlockOpen_reg <= unlockOpen_next;
         settle_reg <= settle_next;
         dutyCnt_reg <= dutyCnt_next;
         rdata_reg <= rdata_next;
      end
   end

   // -----------------------------------------------------------------
   // state kept across warm resets
   // -----------------------------------------------------------------
   // only power-on resets these; the reset request sets the flag before it bites
   always_comb begin
      dropFlag_next = dropFlag_reg;
      filterEn_next = filterEn_reg;
      if (wrPrimary) begin
         dropFlag_next = sfrWdata[bdc_pkg::DROP_RST_FLAG_BIT];
      end
      if (wrSecondary) begin
         filterEn_next = sfrWdata[bdc_pkg::FILTER_EN_BIT];
      end
      if (supplyDropReset) begin
         dropFlag_next = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge porReset_n) begin
      if (!porReset_n) begin
         dropFlag_reg <= 1'b0;
         filterEn_reg <= bdc_pkg::FILTER_EN_RESET;
      end else begin
         dropFlag_reg <= dropFlag_next;
         filterEn_reg <= filterEn_next;
      end
   end

   // -----------------------------------------------------------------
   // filter and outputs
   // -----------------------------------------------------------------
   // power-down forces the slow filter even with the enable off
   assign filtUseSys = filterEn_reg && duty_reg == 2'h0 && !sysClkIsLirc && !powerDown;
   assign filtBypass = !filterEn_reg && !powerDown;

   bdc_noise_filter bdc_noise_filter_inst (
      .clk(clk),
      .reset_n(reset_n),
      .level(cmpSync_reg),
      .sampleEn(detEn_reg && !settling && dutyWindow && loaded),
      .stepEn(filtUseSys || lircTick),
      .bypass(filtBypass),
      .limit(filtUseSys ? bdc_pkg::FILTER_SYS_CLOCKS : bdc_pkg::FILTER_LOW_SPEED_INTERNAL_OSC_TICKS),
      .clear(!detEn_reg),
      .accepted(filtAccepted),
      .change(filtChange)
   );

   assign sfrRdata = rdata_reg;
   assign cmpEnable = detEn_reg && dutyWindow;
   assign cmpThreshold = thr_reg;
   // drop goes to reset when enabled, otherwise only the flag path
   assign supplyDropReset = detEn_reg && dropRstEn_reg && filtAccepted;
   assign irqReq = crossFlag_reg && brownoutIrqEnable && globalIrqEnable;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   locked_write_a: assert property (@(posedge clk) disable iff (!reset_n)
      (sfrWe && sfrAddr == bdc_pkg::CTRL_SECONDARY_ADDR && unlockOpen_reg == 3'h0) |=> $stable(duty_reg))
      else $error("unprotected write changed control");
   flag_sets_a: assert property (@(posedge clk) disable iff (!reset_n)
      filtChange |=> crossFlag_reg)
      else $error("crossing did not set flag");
   flag_holds_a: assert property (@(posedge clk) disable iff (!reset_n)
      (crossFlag_reg && !wrPrimary && load_reg != 2'h1) |=> crossFlag_reg)
      else $error("flag cleared without software");
   irq_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
      irqReq == (crossFlag_reg && brownoutIrqEnable && globalIrqEnable))
      else $error("interrupt request gating wrong");
   status_off_a: assert property (@(posedge clk) disable iff (!reset_n)
      (!detEn_reg && sfrAddr == bdc_pkg::CTRL_PRIMARY_ADDR) |=> !sfrRdata[bdc_pkg::BELOW_STATUS_BIT])
      else $error("status set while detector off");
   drop_flag_a: assert property (@(posedge clk) disable iff (!porReset_n)
      supplyDropReset |=> dropFlag_reg)
      else $error("reset flag not set by drop reset");
   settle_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(detEn_reg) |-> settle_reg == bdc_pkg::SETTLE_LOW_SPEED_INTERNAL_OSC_TICKS)
      else $error("settle time not started on enable");
   config_load_a: assert property (@(posedge clk) disable iff (!reset_n)
      load_reg == 2'h1 |=> detEn_reg == $past(nvDetEn) && dropRstEn_reg == $past(nvDropRst))
      else $error("config bits not reloaded");
   no_reset_a: assert property (@(posedge clk) disable iff (!reset_n)
      !dropRstEn_reg |-> !supplyDropReset)
      else $error("reset requested while disabled");
   // a disabled detector must never power the comparator
   comparator_off_a: assert property (@(posedge clk) disable iff (!reset_n)
      !detEn_reg |-> !cmpEnable)
      else $error("comparator powered while detector off");
   // the reference follows the threshold field
   threshold_out_a: assert property (@(posedge clk) disable iff (!reset_n)
      cmpThreshold == thr_reg)
      else $error("threshold output differs from field");
endmodule
`default_nettype wire

// File: hw/bdc_pkg.sv
package bdc_pkg;
   // ----------------------------------------------------------------
   // register addresses on the special function register bus
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_PRIMARY_ADDR = 8'hA3;
   localparam logic [7:0] CTRL_SECONDARY_ADDR = 8'hAB;
   localparam logic [7:0] TIMED_UNLOCK_ADDR = 8'hC7; // unlock key register
   // ----------------------------------------------------------------
   // field positions, primary control register
   // ----------------------------------------------------------------
   localparam int DET_EN_BIT = 7;
   localparam int THR_LSB = 4;
   localparam int CROSS_FLAG_BIT = 3;
   localparam int DROP_RST_EN_BIT = 2;
   localparam int DROP_RST_FLAG_BIT = 1;
   localparam int BELOW_STATUS_BIT = 0;
   // ----------------------------------------------------------------
   // field positions, secondary control register and config byte
   // ----------------------------------------------------------------
   localparam int DUTY_LSB = 1;
   localparam int FILTER_EN_BIT = 0;
   localparam int NV_DET_EN_BIT = 7;
   localparam int NV_THR_LSB = 4;
   localparam int NV_DROP_RST_BIT = 2;
   // ----------------------------------------------------------------
   // reset values and unlock keys
   // ----------------------------------------------------------------
   localparam logic FILTER_EN_RESET = 1'b1;
   localparam logic [7:0] UNLOCK_KEY_FIRST = 8'hAA;
   localparam logic [7:0] UNLOCK_KEY_SECOND = 8'h55;
   localparam logic [2:0] UNLOCK_WINDOW_CYCLES = 3'h4;
   localparam logic [1:0] LOAD_DELAY_CYCLES = 2'h3;
   // ----------------------------------------------------------------
   // timing counts
   // ----------------------------------------------------------------
   localparam logic [1:0] SETTLE_LOW_SPEED_INTERNAL_OSC_TICKS = 2'h3;
   localparam logic [5:0] FILTER_SYS_CLOCKS = 6'h20;
   localparam logic [5:0] FILTER_LOW_SPEED_INTERNAL_OSC_TICKS = 6'h02;
   localparam logic [8:0] DUTY1_PERIOD_TICKS = 9'h010;
   localparam logic [8:0] DUTY2_PERIOD_TICKS = 9'h040;
   localparam logic [8:0] DUTY3_PERIOD_TICKS = 9'h100;
   localparam logic [8:0] DUTY_ON_TICKS = 9'h002;
endpackage

// File: hw/bdc_noise_filter.sv
`timescale 1ns/1ns
`default_nettype none
module bdc_noise_filter (
   input wire logic clk, // system clock
   input wire logic reset_n, // async reset, active low
   input wire logic level, // synchronised comparator level
   input wire logic sampleEn, // comparator output valid
   input wire logic stepEn, // one filter count step
   input wire logic bypass, // accept level at once
   input wire logic [5:0] limit, // steps the level must persist
   input wire logic clear, // detector off, drop to above
   output logic accepted, // filtered level, 1 = below
   output logic change // one-cycle crossing pulse
);
   logic acc_reg, acc_next;
   logic [5:0] cnt_reg, cnt_next;
   logic chg_reg, chg_next;

   // -----------------------------------------------------------------
   // persistence counter
   // -----------------------------------------------------------------
   // counter restarts whenever a sampled level equals the accepted one
   always_comb begin
      acc_next = acc_reg;
      cnt_next = cnt_reg;
      chg_next = 1'b0;
      if (clear) begin
         acc_next = 1'b0; // no event: disabling is not a crossing
         cnt_next = 6'h00;
      end else if (sampleEn && level != acc_reg) begin
         if (bypass || (stepEn && cnt_reg + 6'h01 >= limit)) begin
            acc_next = level;
            cnt_next = 6'h00;
            chg_next = 1'b1;
         end else if (stepEn) begin
            cnt_next = cnt_reg + 6'h01;
         end
      end else if (sampleEn) begin
         cnt_next = 6'h00;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         acc_reg <= 1'b0;
         cnt_reg <= 6'h00;
         chg_reg <= 1'b0;
      end else begin
         acc_reg <= acc_next;
         cnt_reg <= cnt_next;
         chg_reg <= chg_next;
      end
   end

   assign accepted = acc_reg;
   assign change = chg_reg;

   // every accepted change, except a drop by clear, is reported by exactly one pulse
   change_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
      ($changed(acc_reg) && !$past(clear)) |-> chg_reg)
      else $error("accepted level changed without a crossing pulse");
   // filtered change needs the count to have reached the limit
   persist_a: assert property (@(posedge clk) disable iff (!reset_n)
      (chg_reg && !$past(bypass)) |-> $past(cnt_reg) + 6'h01 >= $past(limit))
      else $error("level accepted before persisting");
endmodule
`default_nettype wire

// File: verif/bdc_supply_model.sv
`timescale 1ns/1ns
`default_nettype none
module bdc_supply_model (
   input wire logic below, // supply under threshold
   output logic lircClk, // slow oscillator
   output logic cmpRaw // comparator output, 1 = below
);
   // ------------------------------------------------
   // slow oscillator and analog comparator
   // ------------------------------------------------
   // odd half period puts only every fifth slow clock edge on the clk grid
   initial begin
      lircClk = 1'b0;
      cmpRaw = 1'b0;
   end
   always #47 begin
      lircClk = ~lircClk;
   end
   // output lags the supply, so it is truly asynchronous
   always @(below) begin
      cmpRaw <= #3 below;
   end
endmodule
`default_nettype wire

// File: verif/brownout_detect_control_bench.sv
`timescale 1ns/1ns
`default_nettype none
module brownout_detect_control_bench;
   logic clk, reset_n, porReset_n, sfrWe, below, powerDown, gie, irqReq, dropRst, cmpEnable, cmpRaw, lircClk;
   logic bie;
   logic [7:0] sfrAddr, sfrWdata, sfrRdata, nvCfg;
   logic [1:0] cmpThreshold;
   int err_count, num_checks;
   localparam logic [7:0] A0 = bdc_pkg::CTRL_PRIMARY_ADDR;
   localparam logic [7:0] A1 = bdc_pkg::CTRL_SECONDARY_ADDR;
   // ------------------------------------------------
   // design, supply model and clock
   // ------------------------------------------------
   bdc_control bdc_control_inst (.clk(clk), .reset_n(reset_n), .porReset_n(porReset_n), .sfrAddr(sfrAddr),
      .sfrWe(sfrWe), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .nvConfigByteTwo(nvCfg), .cmpRaw(cmpRaw),
      .lircClk(lircClk), .sysClkIsLirc(1'b0), .powerDown(powerDown), .brownoutIrqEnable(bie),
      .globalIrqEnable(gie), .cmpEnable(cmpEnable), .cmpThreshold(cmpThreshold), .irqReq(irqReq),
      .supplyDropReset(dropRst));
   bdc_supply_model bdc_supply_model_inst (.below(below), .lircClk(lircClk), .cmpRaw(cmpRaw));
   always #5 begin
      clk = ~clk;
   end
   // ------------------------------------------------
   // access tasks and compares
   // ------------------------------------------------
   task automatic tally_and_finish();
      $display("checks=%0d errors=%0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one strobe cycle then a quiet cycle, so we never rises twice in a step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      sfrAddr = a;
      sfrWdata = d;
      sfrWe = 1'b1;
      @(negedge clk);
      sfrWe = 1'b0;
   endtask
   task automatic twr(input logic [7:0] a, input logic [7:0] d);
      wr(bdc_pkg::TIMED_UNLOCK_ADDR, bdc_pkg::UNLOCK_KEY_FIRST);
      wr(bdc_pkg::TIMED_UNLOCK_ADDR, bdc_pkg::UNLOCK_KEY_SECOND);
      wr(a, d);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      sfrAddr = a;
      @(negedge clk);
      d = sfrRdata;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk8(d, exp);
   endtask
   // bounded poll of the primary register until all mask bits are set
   task automatic poll(input logic [7:0] mask, input int bound);
      logic [7:0] d;
      int n;
      d = 8'h00;
      n = 0;
      while (((d & mask) !== mask) && n < bound) begin
         rd(A0, d);
         n++;
      end
      num_checks++;
      if ((d & mask) !== mask) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, d, mask);
         tally_and_finish();
      end
   endtask
   task automatic doReset();
      reset_n = 1'b0;
      repeat (4) @(negedge clk);
      reset_n = 1'b1;
      repeat (100) @(negedge clk);
   endtask
   // ------------------------------------------------
   // main sequence
   // ------------------------------------------------
   initial begin
      clk = 1'b0;
      reset_n = 1'b0;
      porReset_n = 1'b0;
      sfrWe = 1'b0;
      sfrAddr = 8'h00;
      sfrWdata = 8'h00;
      below = 1'b0;
      powerDown = 1'b0;
      gie = 1'b1;
      bie = 1'b1;
      nvCfg = 8'hB0;
      err_count = 0;
      num_checks = 0;
      repeat (4) @(negedge clk);
      porReset_n = 1'b1;
      reset_n = 1'b1;
      repeat (60) @(negedge clk);
      rdchk(A0, 8'hB0);
      rdchk(A1, 8'h01);
      chk8({6'h00, cmpThreshold}, 8'h03);
      wr(A0, 8'h00);
      rdchk(A0, 8'hB0);
      // fast filter: level must hold 32 clocks before it counts
      below = 1'b1;
      repeat (20) @(negedge clk);
      rdchk(A0, 8'hB0);
      poll(8'h08, 40);
      rdchk(A0, 8'hB9);
      chk8({7'h00, irqReq}, 8'h01);
      chk8({7'h00, dropRst}, 8'h00);
      gie = 1'b0;
      @(negedge clk);
      chk8({7'h00, irqReq}, 8'h00);
      gie = 1'b1;
      bie = 1'b0;
      @(negedge clk);
      chk8({7'h00, irqReq}, 8'h00);
      bie = 1'b1;
      twr(A0, 8'hB1);
      repeat (50) @(negedge clk);
      rdchk(A0, 8'hB1);
      below = 1'b0;
      poll(8'h08, 60);
      rdchk(A0, 8'hB8);
      twr(A0, 8'hB4);
      below = 1'b1;
      poll(8'h02, 60);
      chk8({7'h00, dropRst}, 8'h01);
      // warm reset with supply low: flag starts set, drop flag kept
      doReset();
      rdchk(A0, 8'hBB);
      below = 1'b0;
      repeat (60) @(negedge clk);
      twr(A1, 8'hFF);
      rdchk(A1, 8'h07);
      twr(A1, 8'h00);
      twr(A0, 8'hB2);
      rdchk(A0, 8'hB2);
      // power-down forces the slow filter even with filter off
      powerDown = 1'b1;
      below = 1'b1;
      repeat (3) @(negedge clk);
      rdchk(A0, 8'hB2);
      poll(8'h08, 40);
      below = 1'b0;
      powerDown = 1'b0;
      repeat (40) @(negedge clk);
      twr(A0, 8'hB0);
      below = 1'b1;
      poll(8'h08, 8);
      for (int c = 0; c < 4; c++) begin
         twr(A0, {2'b10, c[1:0], 4'h0});
         chk8({6'h00, cmpThreshold}, {6'h00, c[1:0]});
      end
      for (int m = 1; m < 4; m++) begin
         twr(A1, {5'h00, m[1:0], 1'b1});
         rdchk(A1, {5'h00, m[1:0], 1'b1});
      end
      twr(A0, 8'h00);
      rdchk(A0, 8'h00);
      chk8({7'h00, cmpEnable}, 8'h00);
      rdchk(8'h00, 8'h00);
      tally_and_finish();
   end
   initial begin
      #900000;
      err_count++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
